//--- verilog/ptb_term.sv
// Initiator-side transaction termination handler with APB registers
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module ptb_term
  import ptb_pkg::*;
#(
  parameter int PF_BOUND_LOG2 = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [3:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [7:0] req_dwords,
  input wire logic req_multi,
  input wire logic target_is_primary,
  output logic req_ready,
  input wire logic gnt_n,
  input wire logic lat_expired,
  input wire logic devsel_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  output logic frame_n,
  output logic irdy_n,
  output logic [31:0] bus_addr,
  output logic [3:0] bus_cmd,
  output logic [7:0] data_index,
  output logic done,
  output logic [2:0] init_resp,
  output logic entry_remove,
  output logic data_discard,
  output logic primary_system_error_out_n
);
  if (PF_BOUND_LOG2 < 3 || PF_BOUND_LOG2 > 12) begin : g_bound_check
    $error("PF_BOUND_LOG2 out of range");
  end

  ptb_state_t state, next_state;
  ptb_kind_t kind, next_kind;
  ptb_out_t outc, next_outc;
  logic [31:0] addr, next_addr;
  logic [3:0] cmd, next_cmd;
  logic [7:0] rem, next_rem, idx, next_idx, xcnt, next_xcnt;
  logic multi, next_multi, tpri, next_tpri;
  logic [2:0] dwait, next_dwait;
  logic dseen, next_dseen;
  logic [31:0] tries, next_tries;
  logic next_done, next_remove, next_discard, next_serr;
  logic [2:0] next_resp;
  logic [15:0] ctrl, next_ctrl;
  logic [7:0] evdis, next_evdis;
  logic [31:0] limit, next_limit;
  logic [PTB_ST_W-1:0] stat, next_stat, st_set;

  logic dv, xfer, stp, tabort, retry, disc, mdone, lat_cut, ma_now;
  logic [31:0] addr_inc, next_prdata;
  logic serr_en, wr_acc, rd_acc;

  assign dv = !devsel_n;
  assign xfer = dv && !trdy_n;
  assign stp = !stop_n;
  assign tabort = stp && devsel_n && trdy_n && dseen;
  assign retry = stp && dv && trdy_n && (xcnt == 8'h00);
  assign disc = stp && dv && !retry;
  assign addr_inc = addr + 32'h0000_0004;
  assign ma_now = !dseen && !dv && (dwait == PTB_DEVSEL_CLKS);
  assign serr_en = ctrl[PTB_CTRL_SERR_EN_BIT];

  // Which master-side completion applies to this data phase
  always_comb begin
    mdone = 1'b0;
    case (kind)
      PTB_K_DWRITE, PTB_K_NPREAD, PTB_K_SPECIAL: mdone = 1'b1;
      PTB_K_PWRITE: mdone = (rem == 8'h01);
      PTB_K_PFREAD: mdone = (addr_inc[PF_BOUND_LOG2-1:0] == '0);
      default: mdone = 1'b1;
    endcase
  end
  // Invalidate bursts run to the last requested dword regardless of grant
  assign lat_cut = lat_expired && gnt_n && (cmd != PTB_CMD_MWI);

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_outc = outc;
    next_addr = addr;
    next_cmd = cmd;
    next_rem = rem;
    next_idx = idx;
    next_xcnt = xcnt;
    next_multi = multi;
    next_tpri = tpri;
    next_dwait = dwait;
    next_dseen = dseen;
    next_tries = tries;
    next_done = 1'b0;
    next_remove = 1'b0;
    next_discard = 1'b0;
    next_serr = 1'b0;
    next_resp = PTB_R_NONE;
    st_set = '0;
    case (state)
      PTB_S_IDLE: begin
        if (req_valid) begin
          next_kind = ptb_kind_t'(req_kind);
          next_addr = req_addr;
          next_cmd = (req_kind == PTB_K_SPECIAL) ? PTB_CMD_SPECIAL : req_cmd;
          next_rem = (req_dwords == 8'h00) ? 8'h01 : req_dwords;
          next_idx = 8'h00;
          next_multi = req_multi;
          next_tpri = target_is_primary;
          next_tries = 32'h0000_0000;
          next_state = PTB_S_ADDR;
        end
      end
      PTB_S_ADDR: begin
        next_dwait = 3'h1;
        next_dseen = 1'b0;
        next_xcnt = 8'h00;
        next_tries = tries + 32'h0000_0001;
        next_state = PTB_S_DATA;
      end
      PTB_S_DATA: begin
        if (dv) begin
          next_dseen = 1'b1;
        end else if (!dseen) begin
          next_dwait = dwait + 3'h1;
        end
        if (ma_now) begin
          next_outc = PTB_O_MABORT;
          next_state = PTB_S_TURN;
        end else if (tabort) begin
          next_outc = PTB_O_TABORT;
          next_state = PTB_S_TURN;
        end else if (retry) begin
          next_outc = PTB_O_RETRY;
          next_state = PTB_S_TURN;
        end else if (xfer || disc) begin
          if (xfer) begin
            next_addr = addr_inc;
            next_rem = rem - 8'h01;
            next_idx = idx + 8'h01;
            next_xcnt = xcnt + 8'h01;
          end
          if (xfer && mdone) begin
            next_outc = PTB_O_NORMAL;
            next_state = PTB_S_TURN;
          end else if (disc) begin
            next_outc = PTB_O_DISC;
            next_state = PTB_S_TURN;
          end else if (xfer && lat_cut) begin
            next_outc = PTB_O_LAT;
            next_state = PTB_S_TURN;
          end
        end
      end
      PTB_S_TURN: begin
        next_state = PTB_S_IDLE;
        case (outc)
          PTB_O_MABORT: begin
            next_done = 1'b1;
            if (kind == PTB_K_SPECIAL) begin
              next_resp = PTB_R_DISC;
            end else begin
              st_set[tpri ? PTB_ST_RMA_PRI : PTB_ST_RMA_SEC] = 1'b1;
              if (kind == PTB_K_PWRITE) begin
                next_discard = 1'b1;
                next_serr = ctrl[PTB_CTRL_MA_MODE_BIT] && serr_en &&
                            !evdis[PTB_EVDIS_MAPW_BIT];
              end else begin
                next_resp = PTB_R_MABORT;
                next_remove = 1'b1;
              end
            end
          end
          PTB_O_TABORT: begin
            next_done = 1'b1;
            st_set[tpri ? PTB_ST_RTA_PRI : PTB_ST_RTA_SEC] = 1'b1;
            if (kind == PTB_K_PWRITE) begin
              next_discard = 1'b1;
              next_serr = serr_en;
            end else begin
              st_set[tpri ? PTB_ST_STA_SEC : PTB_ST_STA_PRI] = 1'b1;
              next_resp = PTB_R_TABORT;
              next_remove = 1'b1;
            end
          end
          PTB_O_RETRY: begin
            if (tries >= limit) begin
              next_done = 1'b1;
              next_remove = (kind != PTB_K_PWRITE);
              next_discard = (kind == PTB_K_PWRITE);
              if (kind == PTB_K_DWRITE) begin
                st_set[PTB_ST_DW_LIMIT] = 1'b1;
                next_serr = serr_en && !evdis[PTB_EVDIS_DW_BIT];
              end else if (kind == PTB_K_PWRITE) begin
                st_set[PTB_ST_PW_LIMIT] = 1'b1;
                next_serr = serr_en && !evdis[PTB_EVDIS_PW_BIT];
              end
            end else begin
              // Address untouched: no dword moved on a retry
              next_state = PTB_S_ADDR;
              if (kind == PTB_K_DWRITE)
                next_resp = PTB_R_RETRY;
            end
          end
          PTB_O_DISC, PTB_O_LAT: begin
            if (kind == PTB_K_PWRITE && rem != 8'h00) begin
              next_state = PTB_S_ADDR;
              if (cmd == PTB_CMD_MWI && xcnt != 8'h00)
                next_cmd = PTB_CMD_MEM_WR;
            end else if (outc == PTB_O_DISC && xcnt == 8'h00 &&
                         kind != PTB_K_PFREAD) begin
              next_state = PTB_S_ADDR;
            end else begin
              next_done = 1'b1;
              next_resp = multi ? PTB_R_DISC : PTB_R_DONE;
            end
          end
          default: begin
            next_done = 1'b1;
            if (kind != PTB_K_PWRITE)
              next_resp = (multi || kind == PTB_K_SPECIAL) ? PTB_R_DISC :
                          PTB_R_DONE;
          end
        endcase
      end
      default: next_state = PTB_S_IDLE;
    endcase
    if (next_serr)
      st_set[PTB_ST_SSE_PRI] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PTB_S_IDLE;
      kind <= PTB_K_DWRITE;
      outc <= PTB_O_NORMAL;
      addr <= 32'h0000_0000;
      cmd <= 4'h0;
      rem <= 8'h00;
      idx <= 8'h00;
      xcnt <= 8'h00;
      multi <= 1'b0;
      tpri <= 1'b0;
      dwait <= 3'h0;
      dseen <= 1'b0;
      tries <= 32'h0000_0000;
      done <= 1'b0;
      entry_remove <= 1'b0;
      data_discard <= 1'b0;
      primary_system_error_out_n <= 1'b1;
      init_resp <= PTB_R_NONE;
    end else begin
      state <= next_state;
      kind <= next_kind;
      outc <= next_outc;
      addr <= next_addr;
      cmd <= next_cmd;
      rem <= next_rem;
      idx <= next_idx;
      xcnt <= next_xcnt;
      multi <= next_multi;
      tpri <= next_tpri;
      dwait <= next_dwait;
      dseen <= next_dseen;
      tries <= next_tries;
      done <= next_done;
      entry_remove <= next_remove;
      data_discard <= next_discard;
      primary_system_error_out_n <= !next_serr;
      init_resp <= next_resp;
    end
  end

  assign req_ready = (state == PTB_S_IDLE);
  assign frame_n = !(state == PTB_S_ADDR || state == PTB_S_DATA);
  assign irdy_n = !(state == PTB_S_DATA);
  assign bus_addr = addr;
  assign bus_cmd = cmd;
  assign data_index = idx;

  // APB slave: zero wait states, unmapped offsets answer with pslverr
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == PTB_CTRL_OFF ||
                   paddr == PTB_STAT_OFF || paddr == PTB_LIMIT_OFF ||
                   paddr == PTB_EVDIS_OFF);

  always_comb begin
    next_ctrl = ctrl;
    next_evdis = evdis;
    next_limit = limit;
    next_stat = stat;
    if (wr_acc) begin
      case (paddr)
        PTB_CTRL_OFF: next_ctrl = pwdata[15:0];
        PTB_STAT_OFF: next_stat = stat & ~pwdata[PTB_ST_W-1:0];
        PTB_LIMIT_OFF: next_limit = pwdata;
        PTB_EVDIS_OFF: next_evdis = pwdata[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // A flag raised in the clearing cycle survives the clear
    next_stat = next_stat | st_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= PTB_CTRL_RST;
      evdis <= PTB_EVDIS_RST;
      limit <= PTB_LIMIT_RST;
      stat <= '0;
    end else begin
      ctrl <= next_ctrl;
      evdis <= next_evdis;
      limit <= next_limit;
      stat <= next_stat;
    end
  end

  // Read data is captured in the setup cycle, so a flag raised during
  // the access cycle shows on the next read
  always_comb begin
    next_prdata = prdata;
    if (rd_acc) begin
      case (paddr)
        PTB_CTRL_OFF: next_prdata = {16'h0000, ctrl};
        PTB_STAT_OFF: next_prdata = {{(32-PTB_ST_W){1'b0}}, stat};
        PTB_LIMIT_OFF: next_prdata = limit;
        PTB_EVDIS_OFF: next_prdata = {24'h000000, evdis};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Checks
  sequence s_no_claim;
    (state == PTB_S_DATA && devsel_n && !dseen);
  endsequence
  property p_mabort_timing;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_DATA && ma_now) |=> (outc == PTB_O_MABORT);
  endproperty
  a_mabort_timing: assert property (p_mabort_timing)
    else $error("master abort not taken on fifth clock");
  property p_no_early_abort;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == PTB_S_DATA) ##0 s_no_claim [*4] |=>
        (outc != PTB_O_MABORT || state != PTB_S_TURN);
  endproperty
  a_no_early_abort: assert property (p_no_early_abort)
    else $error("master abort before five clocks");
  property p_ta_needs_devsel;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_DATA && !stop_n && devsel_n && trdy_n && dseen) |=>
        state == PTB_S_TURN && outc == PTB_O_TABORT;
  endproperty
  a_ta_needs_devsel: assert property (p_ta_needs_devsel)
    else $error("target abort after devsel not recognised");
  property p_ma_pw_discard;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_MABORT && kind == PTB_K_PWRITE)
        |=> data_discard && state == PTB_S_IDLE;
  endproperty
  a_ma_pw_discard: assert property (p_ma_pw_discard)
    else $error("posted write not dropped after master abort");
  property p_ma_reflect;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_MABORT &&
       kind == PTB_K_DWRITE) |=> entry_remove && init_resp == PTB_R_MABORT;
  endproperty
  a_ma_reflect: assert property (p_ma_reflect)
    else $error("delayed master abort not reflected");
  property p_special_noflag;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_MABORT && kind == PTB_K_SPECIAL)
        |=> $stable(stat[PTB_ST_RMA_PRI]) && $stable(stat[PTB_ST_RMA_SEC]);
  endproperty
  a_special_noflag: assert property (p_special_noflag)
    else $error("special cycle set master abort flag");
  property p_retry_same_addr;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_RETRY && tries < limit)
        |=> state == PTB_S_ADDR && $stable(addr);
  endproperty
  a_retry_same_addr: assert property (p_retry_same_addr)
    else $error("retry changed start address");
  property p_single_dword;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_DATA && xfer && kind == PTB_K_DWRITE)
        |=> state == PTB_S_TURN ##1 state == PTB_S_IDLE;
  endproperty
  a_single_dword: assert property (p_single_dword)
    else $error("delayed write ran past one dword");
  property p_mwi_fallback;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_DISC && kind == PTB_K_PWRITE &&
       cmd == PTB_CMD_MWI && xcnt != 8'h00 && rem != 8'h00)
        |=> bus_cmd == PTB_CMD_MEM_WR;
  endproperty
  a_mwi_fallback: assert property (p_mwi_fallback)
    else $error("invalidate write not downgraded");
  property p_ta_serr;
    @(posedge pclk) disable iff (!presetn)
      (state == PTB_S_TURN && outc == PTB_O_TABORT && kind == PTB_K_PWRITE &&
       serr_en) |=> !primary_system_error_out_n ##1 stat[PTB_ST_SSE_PRI];
  endproperty
  a_ta_serr: assert property (p_ta_serr)
    else $error("posted target abort missed system error");
endmodule : ptb_term

//--- verilog/ptb_pkg.sv
// Constants and types for the bridge initiator termination handler
package ptb_pkg;
  // Register byte offsets
  localparam logic [7:0] PTB_CTRL_OFF = 8'h00;
  localparam logic [7:0] PTB_STAT_OFF = 8'h04;
  localparam logic [7:0] PTB_LIMIT_OFF = 8'h08;
  localparam logic [7:0] PTB_EVDIS_OFF = 8'h64;
  // Control fields
  localparam int PTB_CTRL_MA_MODE_BIT = 5;
  localparam int PTB_CTRL_SERR_EN_BIT = 8;
  // Event disable fields
  localparam int PTB_EVDIS_PW_BIT = 2;
  localparam int PTB_EVDIS_MAPW_BIT = 4;
  localparam int PTB_EVDIS_DW_BIT = 5;
  // Status fields (write one to clear)
  localparam int PTB_ST_RMA_PRI = 0;
  localparam int PTB_ST_RMA_SEC = 1;
  localparam int PTB_ST_RTA_PRI = 2;
  localparam int PTB_ST_RTA_SEC = 3;
  localparam int PTB_ST_STA_PRI = 4;
  localparam int PTB_ST_STA_SEC = 5;
  localparam int PTB_ST_SSE_PRI = 6;
  localparam int PTB_ST_DW_LIMIT = 7;
  localparam int PTB_ST_PW_LIMIT = 8;
  localparam int PTB_ST_W = 9;
  // Reset values
  localparam logic [15:0] PTB_CTRL_RST = 16'h0000;
  localparam logic [7:0] PTB_EVDIS_RST = 8'h00;
  localparam logic [31:0] PTB_LIMIT_RST = 32'h0100_0000;
  // Timing: clocks allowed for a target to claim
  localparam logic [2:0] PTB_DEVSEL_CLKS = 3'h5;
  // Bus commands
  localparam logic [3:0] PTB_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PTB_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PTB_CMD_MWI = 4'hf;
  typedef enum logic [2:0] {
    PTB_K_DWRITE = 3'b000, PTB_K_PWRITE = 3'b001, PTB_K_NPREAD = 3'b010,
    PTB_K_PFREAD = 3'b011, PTB_K_SPECIAL = 3'b100
  } ptb_kind_t;
  typedef enum logic [2:0] {
    PTB_R_NONE = 3'b000, PTB_R_DONE = 3'b001, PTB_R_DISC = 3'b010,
    PTB_R_RETRY = 3'b011, PTB_R_TABORT = 3'b100, PTB_R_MABORT = 3'b101
  } ptb_resp_t;
  typedef enum logic [2:0] {
    PTB_O_NORMAL = 3'b000, PTB_O_RETRY = 3'b001, PTB_O_DISC = 3'b010,
    PTB_O_TABORT = 3'b011, PTB_O_MABORT = 3'b100, PTB_O_LAT = 3'b101
  } ptb_out_t;
  typedef enum logic [1:0] {
    PTB_S_IDLE = 2'b00, PTB_S_ADDR = 2'b01, PTB_S_DATA = 2'b10,
    PTB_S_TURN = 2'b11
  } ptb_state_t;
endpackage : ptb_pkg

//--- verif/ptb_target_model.sv
// Far-side target model answering the handler's transactions
`timescale 1ns/1ps
module ptb_target_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [2:0] mode,
  input wire logic [2:0] dly,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n
);
  // Modes: 0 silent, 1 normal, 2 retry, 3 abort, 4 disconnect with data
  logic [3:0] cnt;
  logic hit;
  logic ab;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else begin
      cnt <= irdy_n ? 4'h0 : cnt + 4'h1;
    end
  end
  // Released lines sit on their pull-ups, so they read high
  always_comb begin
    hit = !irdy_n && cnt >= {1'b0, dly} && mode != 3'h0;
    ab = mode == 3'h3 && cnt > {1'b0, dly};
    devsel_n = !hit || ab;
    trdy_n = !(hit && (mode == 3'h1 || mode == 3'h4));
    stop_n = !(hit && (mode == 3'h2 || mode == 3'h4 || ab));
  end
endmodule : ptb_target_model

//--- verif/tb_pci_bridge_termination_handler.sv
// Self-checking bench for the initiator termination handler
`timescale 1ns/1ps
module tb_pci_bridge_termination_handler
  import ptb_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, req_valid = 1'b0, req_multi = 1'b0, cut = 1'b0;
  logic target_is_primary = 1'b0, gnt_n = 1'b0, lat_expired = 1'b0;
  logic [7:0] paddr = 8'h00, req_dwords = 8'h01, data_index;
  logic [31:0] pwdata = 32'h0, req_addr = 32'h0, prdata, bus_addr, q;
  logic [2:0] req_kind = 3'h0, mode = 3'h1, dly = 3'h0, init_resp, resp;
  logic [3:0] req_cmd = 4'h7, bus_cmd;
  logic pready, pslverr, req_ready, frame_n, irdy_n, done, perr;
  logic entry_remove, data_discard, primary_system_error_out_n;
  logic devsel_n, trdy_n, stop_n;
  logic got = 1'b0, serr = 1'b0, rem = 1'b0, disc = 1'b0, rty = 1'b0;
  int miscompares = 0, n_tests = 0, cyc = 0, att = 0, xfers = 0;

  ptb_term #(.PF_BOUND_LOG2(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_kind(req_kind), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_dwords(req_dwords), .req_multi(req_multi),
    .target_is_primary(target_is_primary), .req_ready(req_ready),
    .gnt_n(gnt_n), .lat_expired(lat_expired), .devsel_n(devsel_n),
    .trdy_n(trdy_n), .stop_n(stop_n), .frame_n(frame_n), .irdy_n(irdy_n),
    .bus_addr(bus_addr), .bus_cmd(bus_cmd), .data_index(data_index),
    .done(done), .init_resp(init_resp), .entry_remove(entry_remove),
    .data_discard(data_discard),
    .primary_system_error_out_n(primary_system_error_out_n)
  );
  ptb_target_model tgt (
    .pclk(pclk), .presetn(presetn), .frame_n(frame_n), .irdy_n(irdy_n),
    .mode(mode), .dly(dly), .devsel_n(devsel_n), .trdy_n(trdy_n),
    .stop_n(stop_n)
  );

  always #4 pclk = ~pclk;

  // Grant is pulled once a burst is under way, so a cut can happen
  always @(posedge pclk) begin
    gnt_n <= cut && frame_n === 1'b0;
    lat_expired <= cut && frame_n === 1'b0;
  end

  task automatic chk(input string nm, input logic [31:0] v,
                     input logic [31:0] e);
    n_tests = n_tests + 1;
    if (v !== e) begin
      miscompares = miscompares + 1;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(negedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  // Sampled mid-cycle so registered outputs have settled
  always @(negedge pclk) begin
    if (frame_n === 1'b0 && irdy_n === 1'b1) begin
      att = att + 1;
      chk("addr", bus_addr, req_addr + 4*xfers);
      chk("index", data_index, xfers);
      chk("busy", req_ready, 1'b0);
      if (xfers > 0 && req_cmd === PTB_CMD_MWI) begin
        chk("resume_cmd", bus_cmd, PTB_CMD_MEM_WR);
      end
    end
    if (irdy_n === 1'b0 && devsel_n === 1'b0 && trdy_n === 1'b0) begin
      xfers = xfers + 1;
    end
    serr |= primary_system_error_out_n === 1'b0;
    rem |= entry_remove === 1'b1;
    disc |= data_discard === 1'b1;
    rty |= init_resp === PTB_R_RETRY;
    if (done === 1'b1) begin
      got = 1'b1;
      resp = init_resp;
      chk("ready", req_ready, 1'b1);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Clears status first, leaves the status word in q afterwards
  task automatic run(input logic [2:0] k, input logic [31:0] a,
                     input logic [7:0] n, input logic m = 1'b0,
                     input logic [3:0] c = PTB_CMD_MEM_WR);
    int i;
    apb(1'b1, PTB_STAT_OFF, 32'h1ff);
    {got, serr, rem, disc, rty} = 5'h0;
    att = 0;
    xfers = 0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_cmd <= c;
    req_addr <= a;
    req_dwords <= n;
    req_multi <= m;
    @(posedge pclk);
    req_valid <= 1'b0;
    for (i = 0; i < 500 && got !== 1'b1; i++) @(posedge pclk);
    chk("done", got, 1'b1);
    apb(1'b0, PTB_STAT_OFF, 32'h0);
  endtask : run

  task automatic t_regs();
    apb(1'b0, PTB_CTRL_OFF, 32'h0);
    chk("ctrl_rst", q, PTB_CTRL_RST);
    apb(1'b0, PTB_LIMIT_OFF, 32'h0);
    chk("limit_rst", q, PTB_LIMIT_RST);
    apb(1'b0, PTB_EVDIS_OFF, 32'h0);
    chk("evdis_rst", q, PTB_EVDIS_RST);
    apb(1'b1, PTB_EVDIS_OFF, 32'h34);
    apb(1'b0, PTB_EVDIS_OFF, 32'h0);
    chk("evdis_rw", q, 32'h34);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", perr, 1'b1);
    chk("unmapped_rd", q, 32'h0);
    apb(1'b1, PTB_EVDIS_OFF, 32'h0);
  endtask : t_regs

  task automatic t_normal();
    mode <= 3'h1;
    dly <= 3'h4;
    run(PTB_K_DWRITE, 32'h100, 8'h04, 1'b1);
    chk("dw_resp", resp, PTB_R_DISC);
    chk("dw_xfers", xfers, 1);
    mode <= 3'h4;
    dly <= 3'h0;
    run(PTB_K_DWRITE, 32'h100, 8'h01);
    chk("dw1_resp", resp, PTB_R_DONE);
    mode <= 3'h1;
    run(PTB_K_PWRITE, 32'h200, 8'h05);
    chk("pw_xfers", xfers, 5);
    chk("pw_att", att, 1);
    run(PTB_K_NPREAD, 32'h300, 8'h04, 1'b0, 4'h6);
    chk("np_xfers", xfers, 1);
    run(PTB_K_PFREAD, 32'h338, 8'h08, 1'b0, 4'hc);
    chk("pf_xfers", xfers, 2);
  endtask : t_normal

  task automatic t_mabort();
    int j;
    mode <= 3'h0;
    run(PTB_K_DWRITE, 32'h400, 8'h01);
    chk("ma_resp", resp, PTB_R_MABORT);
    chk("ma_remove", rem, 1'b1);
    chk("ma_flag", q[PTB_ST_RMA_SEC], 1'b1);
    for (j = 0; j < 3; j++) begin
      apb(1'b1, PTB_CTRL_OFF, j == 2 ? 32'h100 : 32'h120);
      apb(1'b1, PTB_EVDIS_OFF, j == 1 ? 32'h10 : 32'h0);
      run(PTB_K_PWRITE, 32'h400, 8'h03);
      chk("mapw_serr", serr, j == 0);
      chk("mapw_discard", disc, 1'b1);
      chk("mapw_att", att, 1);
    end
    run(PTB_K_SPECIAL, 32'h0, 8'h02, 1'b1, PTB_CMD_SPECIAL);
    chk("sc_resp", resp, PTB_R_DISC);
    chk("sc_flag", q[1:0], 2'h0);
  endtask : t_mabort

  task automatic t_limits();
    int j;
    mode <= 3'h2;
    apb(1'b1, PTB_CTRL_OFF, 32'h120);
    apb(1'b1, PTB_LIMIT_OFF, 32'h3);
    for (j = 0; j < 4; j++) begin
      apb(1'b1, PTB_EVDIS_OFF, j < 2 ? 32'h0 : (j == 2 ? 32'h20 : 32'h4));
      run(3'(j % 2), 32'h500, 8'h02);
      chk("rt_att", att, 3);
      chk("rt_lim", q[PTB_ST_DW_LIMIT + j % 2], 1'b1);
      chk("rt_serr", serr, j < 2);
      if (j % 2 == 0) chk("rt_code", rty, 1'b1);
    end
    apb(1'b1, PTB_EVDIS_OFF, 32'h0);
  endtask : t_limits

  task automatic t_abort();
    mode <= 3'h3;
    dly <= 3'h1;
    target_is_primary <= 1'b1;
    run(PTB_K_DWRITE, 32'h600, 8'h01);
    chk("ta_resp", resp, PTB_R_TABORT);
    chk("ta_rcvd", q[PTB_ST_RTA_PRI], 1'b1);
    chk("ta_sig", q[PTB_ST_STA_SEC], 1'b1);
    target_is_primary <= 1'b0;
    run(PTB_K_PWRITE, 32'h600, 8'h02);
    chk("tapw_rcvd", q[PTB_ST_RTA_SEC], 1'b1);
    chk("tapw_serr", serr, 1'b1);
    chk("tapw_sse", q[PTB_ST_SSE_PRI], 1'b1);
  endtask : t_abort

  task automatic t_resume();
    mode <= 3'h4;
    dly <= 3'h0;
    run(PTB_K_PWRITE, 32'h700, 8'h04, 1'b0, PTB_CMD_MWI);
    chk("dc_xfers", xfers, 4);
    chk("dc_att", att, 4);
    mode <= 3'h1;
    cut <= 1'b1;
    run(PTB_K_PWRITE, 32'h800, 8'h06);
    chk("lt_xfers", xfers, 6);
    chk("lt_cut", att > 1, 1'b1);
    run(PTB_K_PWRITE, 32'h800, 8'h06, 1'b0, PTB_CMD_MWI);
    chk("lt_mwi_att", att, 1);
    run(PTB_K_PFREAD, 32'h900, 8'h08, 1'b0, 4'hc);
    chk("lt_pf_att", att, 1);
    cut <= 1'b0;
  endtask : t_resume

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_normal();
    t_mabort();
    t_limits();
    t_abort();
    t_resume();
    print_verdict();
  end
endmodule : tb_pci_bridge_termination_handler
